// File: logic/mirq_defines.svh
// Purpose: Offsets, field positions, reset values and timing counts of the MAC
//          interrupt, management and filter register bank.
// Assumes: 8-bit word-aligned byte addresses, 100 MHz system clock.
// Notes:   Definitions only.
`ifndef MIRQ_DEFINES_SVH
`define MIRQ_DEFINES_SVH
// Register byte offsets
`define MIRQ_OFS_STATUS 8'h00
`define MIRQ_OFS_IEN 8'h04
`define MIRQ_OFS_IDIS 8'h08
`define MIRQ_OFS_IMASK 8'h0C
`define MIRQ_OFS_MAN 8'h10
`define MIRQ_OFS_PAUSE 8'h14
`define MIRQ_OFS_HASH_LO 8'h18
`define MIRQ_OFS_HASH_HI 8'h1C
`define MIRQ_OFS_SA1_LO 8'h20
`define MIRQ_OFS_MSTAT 8'h24
// Interrupt vector layout
`define MIRQ_IRQ_W 14
`define MIRQ_IRQ_VALID 14'h3CFF
`define MIRQ_IRQ_EXT 14'h1CFE
`define MIRQ_IRQ_MGMT 0
`define MIRQ_IRQ_PTZ 13
`define MIRQ_RST_MASK 14'h3CFF
// Management status bits
`define MIRQ_MSTAT_LEVEL 1
`define MIRQ_MSTAT_IDLE 2
// Management frame codes
`define MIRQ_SOF_OK 2'h1
`define MIRQ_OP_READ 2'h2
`define MIRQ_OP_WRITE 2'h1
`define MIRQ_MDIO_BITS 7'h40
`define MIRQ_MDIO_TA_BIT 7'h2E
`define MIRQ_MDIO_DATA_BIT 7'h30
// Timing
`define MIRQ_CLK_PERIOD_NS 10
`define MIRQ_BIT_TIME_NS 10
`define MIRQ_PAUSE_QUANTUM_BITS 512
`define MIRQ_QUANTUM_CLKS ((`MIRQ_PAUSE_QUANTUM_BITS * `MIRQ_BIT_TIME_NS) / `MIRQ_CLK_PERIOD_NS)
`define MIRQ_MDC_HALF_NS 200
`define MIRQ_MDC_HALF_CLKS ((`MIRQ_MDC_HALF_NS + `MIRQ_CLK_PERIOD_NS - 1) / `MIRQ_CLK_PERIOD_NS)
`endif

// File: logic/mirq_mdio.sv
// Purpose: Serial management frame shifter with preamble, turnaround release
//          and read data capture.
// Assumes: Caller only starts it when idle and with a valid frame.
// Notes:   Output changes after the falling clock edge, input sampled at rising.
`include "mirq_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module mirq_mdio #(
   parameter int HALF_CLKS = `MIRQ_MDC_HALF_CLKS
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic start,
   input wire mirq_pkg::mirq_man_s frame,
   output logic busy,
   output logic done,
   output logic [15:0] rd_data,
   output logic mdio_level,
   output logic mdc,
   output logic mdio_out,
   output logic mdio_oe_n,
   input wire logic mdio_in
);
   localparam int DW = $clog2(HALF_CLKS + 1);
   mirq_pkg::mirq_mst_e st_q, st_d;
   logic [DW-1:0] div_q, div_d;
   logic [6:0] bit_q, bit_d;
   logic [63:0] sh_q, sh_d;
   logic [15:0] rd_q, rd_d;
   logic mdc_q, mdc_d, out_q, out_d, oen_q, oen_d, done_q, done_d, rdop_q, rdop_d;
   logic s1_q, s2_q;

   // Next state: one bit per full management clock, preamble of ones first
   always_comb
   begin
      st_d = st_q;
      div_d = div_q;
      bit_d = bit_q;
      sh_d = sh_q;
      rd_d = rd_q;
      mdc_d = mdc_q;
      out_d = out_q;
      oen_d = oen_q;
      done_d = 1'b0;
      rdop_d = rdop_q;
      unique case (st_q)
         mirq_pkg::MS_IDLE:
            if (start)
            begin
               st_d = mirq_pkg::MS_RUN;
               sh_d = {32'hFFFFFFFF, frame};
               rdop_d = (frame.op == `MIRQ_OP_READ);
               bit_d = 7'h00;
               div_d = '0;
               mdc_d = 1'b0;
            end
         mirq_pkg::MS_RUN:
            if (div_q == DW'(HALF_CLKS - 1))
            begin
               div_d = '0;
               mdc_d = !mdc_q;
               if (mdc_q)
               begin
                  if (bit_q == `MIRQ_MDIO_BITS)
                  begin
                     st_d = mirq_pkg::MS_IDLE;
                     oen_d = 1'b1;
                     done_d = 1'b1; // [R11]
                  end
                  else
                  begin
                     out_d = sh_q[63];
                     sh_d = {sh_q[62:0], 1'b0};
                     bit_d = bit_q + 7'h01;
                     // Release the pin from turnaround on for a read
                     oen_d = rdop_q && (bit_q >= `MIRQ_MDIO_TA_BIT);
                  end
               end
               else if (rdop_q && (bit_q > `MIRQ_MDIO_DATA_BIT))
                  rd_d = {rd_q[14:0], s2_q}; // [R07]
            end
            else
               div_d = div_q + DW'(1);
      endcase
   end

   // Registers; the pin input passes two flops before use
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         st_q <= mirq_pkg::MS_IDLE;
         div_q <= '0;
         bit_q <= 7'h00;
         sh_q <= 64'h0;
         rd_q <= 16'h0000;
         mdc_q <= 1'b0;
         out_q <= 1'b0;
         oen_q <= 1'b1;
         done_q <= 1'b0;
         rdop_q <= 1'b0;
         s1_q <= 1'b0;
         s2_q <= 1'b0;
      end
      else
      begin
         st_q <= st_d;
         div_q <= div_d;
         bit_q <= bit_d;
         sh_q <= sh_d;
         rd_q <= rd_d;
         mdc_q <= mdc_d;
         out_q <= out_d;
         oen_q <= oen_d;
         done_q <= done_d;
         rdop_q <= rdop_d;
         s1_q <= mdio_in;
         s2_q <= s1_q;
      end
   end

   assign busy = (st_q == mirq_pkg::MS_RUN);
   assign done = done_q;
   assign rd_data = rd_q;
   assign mdio_level = s2_q;
   assign mdc = mdc_q;
   assign mdio_out = out_q;
   assign mdio_oe_n = oen_q;
endmodule
`default_nettype wire

// File: logic/mirq_pkg.sv
// Purpose: Types shared by the register bank and its management shifter.
// Assumes: Nothing beyond the defines header.
// Notes:   Field order of the frame struct is the register bit order.
package mirq_pkg;
   // Management frame word as stored and shifted
   typedef struct packed {
      logic [1:0] sof;
      logic [1:0] op;
      logic [4:0] phy_select_field;
      logic [4:0] phy_register_field;
      logic [1:0] ta;
      logic [15:0] data;
   } mirq_man_s;

   // Management shifter states
   typedef enum logic {MS_IDLE, MS_RUN} mirq_mst_e;
endpackage

// File: logic/mirq_regs.sv
// Purpose: MAC interrupt enable/disable/mask, status, PHY management frame,
//          pause timer, hash filter and first specific address registers.
// Assumes: Event inputs come from logic on CLK; MDIO pin is asynchronous.
// Notes:   Status is cleared by its read, an event in that cycle still sets.
// How it works
// [R01] Enable register is write-only, one bit per source, bits 0-7 and 10-13.
// [R02] Disable register is write-only, same layout, each bit masks its source.
// [R03] Mask register is read-only and reports each source's current mask state.
// [R04] Ones written to enable unmask, to disable mask; zeros change nothing.
// [R05] Interrupt output high while any set status bit is unmasked.
// [R06] Management word: start, operation, PHY, register, turnaround, 16 data bits.
// [R07] Write data goes out to the PHY; read data from the PHY lands in data.
// [R08] Software writes turnaround as 10; the field reads back as written.
// [R09] Operation 10 reads, 01 writes, anything else makes the frame invalid.
// [R10] Software writes start-of-frame as 01 for the frame to be valid.
// [R11] Finished operation sets the management-done flag and shows the logic idle.
// [R12] Pause count is 16 bits and drops by one every 512 bit times.
// [R13] Pause count reaching zero sets a flag that a status read clears.
// [R14] Hash low register holds filter bits 31:0.
// [R15] Hash high register holds filter bits 63:32.
// [R16] Specific address low holds address bits 31:0, bit zero multicast flag.
`include "mirq_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module mirq_regs #(
   parameter int QUANTUM_CLKS = `MIRQ_QUANTUM_CLKS,
   parameter int MDC_HALF_CLKS = `MIRQ_MDC_HALF_CLKS
) (
   input wire logic CLK,
   input wire logic NRST,
   input wire logic [7:0] ADDR,
   input wire logic [31:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [31:0] RDATA,
   input wire logic [`MIRQ_IRQ_W-1:0] EVENT_IN,
   input wire logic PAUSE_LOAD,
   input wire logic [15:0] PAUSE_VALUE,
   output logic PAUSE_ACTIVE,
   output logic IRQ,
   output logic [63:0] HASH_FILTER,
   output logic [31:0] SPEC_ADDR_LOW,
   output logic MDC,
   input wire logic MDIO_IN,
   output logic MDIO_OUT,
   output logic MDIO_OE_N
);
   localparam logic [`MIRQ_IRQ_W-1:0] VALID = `MIRQ_IRQ_VALID;
   localparam int QW = $clog2(QUANTUM_CLKS + 1);

   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      return a == ofs;
   endfunction

   // Only start 01 with operation 10 or 01 makes a frame worth sending
   function automatic logic frame_ok(input mirq_pkg::mirq_man_s f);
      return (f.sof == `MIRQ_SOF_OK) && // [R10]
         ((f.op == `MIRQ_OP_READ) || (f.op == `MIRQ_OP_WRITE)); // [R09]
   endfunction

   logic wr_en, wr_dis, wr_man, wr_pt, wr_hl, wr_hh, wr_sa, rd_st;
   logic [`MIRQ_IRQ_W-1:0] mask_q, mask_d, stat_q, stat_d, set_v;
   mirq_pkg::mirq_man_s man_q, man_d;
   logic [15:0] pause_q, pause_d;
   logic [QW-1:0] qcnt_q, qcnt_d;
   logic [31:0] hl_q, hl_d, hh_q, hh_d, sa_q, sa_d, rdata_q, rdata_d;
   logic inv_q, inv_d, tick, ptz_evt;
   logic mdio_start, mdio_busy, mdio_done, mdio_level;
   logic [15:0] mdio_rd;

   // Address decode of the strobes
   assign wr_en = WR && hit(ADDR, `MIRQ_OFS_IEN);
   assign wr_dis = WR && hit(ADDR, `MIRQ_OFS_IDIS);
   assign wr_man = WR && hit(ADDR, `MIRQ_OFS_MAN);
   assign wr_pt = WR && hit(ADDR, `MIRQ_OFS_PAUSE);
   assign wr_hl = WR && hit(ADDR, `MIRQ_OFS_HASH_LO);
   assign wr_hh = WR && hit(ADDR, `MIRQ_OFS_HASH_HI);
   assign wr_sa = WR && hit(ADDR, `MIRQ_OFS_SA1_LO);
   assign rd_st = RD && hit(ADDR, `MIRQ_OFS_STATUS);

   // Mask: a one means masked; unused bit positions never change
   always_comb
   begin
      mask_d = mask_q;
      if (wr_en)
         mask_d = mask_d & ~(WDATA[`MIRQ_IRQ_W-1:0] & VALID); // [R01] [R04]
      if (wr_dis)
         mask_d = mask_d | (WDATA[`MIRQ_IRQ_W-1:0] & VALID); // [R02] [R04]
   end

   // Status: read clears, but a same-cycle event wins over the clear
   always_comb
   begin
      set_v = EVENT_IN & `MIRQ_IRQ_EXT;
      set_v[`MIRQ_IRQ_MGMT] = mdio_done || inv_q; // [R11]
      set_v[`MIRQ_IRQ_PTZ] = ptz_evt; // [R13]
      stat_d = (rd_st ? '0 : stat_q) | set_v;
   end

   // Masking is on the stored bits so a masked source keeps its history
   assign IRQ = |(stat_q & ~mask_q); // [R05]

   // Management word: writes while a frame runs are dropped to keep it stable
   always_comb
   begin
      man_d = man_q;
      inv_d = 1'b0;
      // Returned data first, so a write landing in the done cycle is kept whole
      if (mdio_done && (man_q.op == `MIRQ_OP_READ))
         man_d.data = mdio_rd; // [R07]
      if (wr_man && !mdio_busy)
      begin
         man_d = mirq_pkg::mirq_man_s'(WDATA); // [R06] [R08]
         inv_d = !frame_ok(mirq_pkg::mirq_man_s'(WDATA)); // [R09]
      end
   end
   assign mdio_start = wr_man && !mdio_busy && frame_ok(mirq_pkg::mirq_man_s'(WDATA)); // [R09]

   // Pause timer: software write beats a received pause load
   assign tick = (pause_q != 16'h0000) && (qcnt_q == QW'(QUANTUM_CLKS - 1));
   assign ptz_evt = tick && (pause_q == 16'h0001) && !wr_pt && !PAUSE_LOAD; // [R13]
   always_comb
   begin
      pause_d = pause_q;
      qcnt_d = qcnt_q;
      if (wr_pt)
      begin
         pause_d = WDATA[15:0];
         qcnt_d = '0;
      end
      else if (PAUSE_LOAD)
      begin
         pause_d = PAUSE_VALUE;
         qcnt_d = '0;
      end
      else if (pause_q != 16'h0000)
      begin
         if (tick)
         begin
            pause_d = pause_q - 16'h0001; // [R12]
            qcnt_d = '0;
         end
         else
            qcnt_d = qcnt_q + QW'(1);
      end
   end

   // Filter and address words are plain storage for the compare logic
   always_comb
   begin
      hl_d = wr_hl ? WDATA : hl_q; // [R14]
      hh_d = wr_hh ? WDATA : hh_q; // [R15]
      sa_d = wr_sa ? WDATA : sa_q; // [R16]
   end

   // Read mux; write-only and unmapped words read zero
   always_comb
   begin
      rdata_d = 32'h00000000;
      if (RD)
      begin
         unique case (ADDR)
            `MIRQ_OFS_STATUS: rdata_d[`MIRQ_IRQ_W-1:0] = stat_q;
            `MIRQ_OFS_IMASK: rdata_d[`MIRQ_IRQ_W-1:0] = mask_q; // [R03]
            `MIRQ_OFS_MAN: rdata_d = man_q; // [R08]
            `MIRQ_OFS_PAUSE: rdata_d[15:0] = pause_q;
            `MIRQ_OFS_HASH_LO: rdata_d = hl_q;
            `MIRQ_OFS_HASH_HI: rdata_d = hh_q;
            `MIRQ_OFS_SA1_LO: rdata_d = sa_q;
            `MIRQ_OFS_MSTAT:
            begin
               rdata_d[`MIRQ_MSTAT_LEVEL] = mdio_level;
               rdata_d[`MIRQ_MSTAT_IDLE] = !mdio_busy; // [R11]
            end
            default: rdata_d = 32'h00000000;
         endcase
      end
   end

   // All bank registers
   always_ff @(posedge CLK)
   begin
      if (!NRST)
      begin
         mask_q <= `MIRQ_RST_MASK;
         stat_q <= '0;
         man_q <= '0;
         inv_q <= 1'b0;
         pause_q <= 16'h0000;
         qcnt_q <= '0;
         hl_q <= 32'h00000000;
         hh_q <= 32'h00000000;
         sa_q <= 32'h00000000;
         rdata_q <= 32'h00000000;
      end
      else
      begin
         mask_q <= mask_d;
         stat_q <= stat_d;
         man_q <= man_d;
         inv_q <= inv_d;
         pause_q <= pause_d;
         qcnt_q <= qcnt_d;
         hl_q <= hl_d;
         hh_q <= hh_d;
         sa_q <= sa_d;
         rdata_q <= rdata_d;
      end
   end

   assign RDATA = rdata_q;
   assign PAUSE_ACTIVE = (pause_q != 16'h0000);
   assign HASH_FILTER = {hh_q, hl_q};
   assign SPEC_ADDR_LOW = sa_q;

   // Serial management shifter
   mirq_mdio #(
      .HALF_CLKS(MDC_HALF_CLKS)
   ) u_mdio (
      .clk(CLK),
      .nrst(NRST),
      .start(mdio_start),
      .frame(mirq_pkg::mirq_man_s'(WDATA)),
      .busy(mdio_busy),
      .done(mdio_done),
      .rd_data(mdio_rd),
      .mdio_level(mdio_level),
      .mdc(MDC),
      .mdio_out(MDIO_OUT),
      .mdio_oe_n(MDIO_OE_N),
      .mdio_in(MDIO_IN)
   );

   // Checks
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!NRST);

   AST_EN_UNMASK: assert property (wr_en |=> // [R01]
      ((mask_q & $past(WDATA[`MIRQ_IRQ_W-1:0]) & VALID) == '0))
      else $error("Enable write left a source masked");
   AST_DIS_MASK: assert property (wr_dis |=> // [R02]
      ((~mask_q & $past(WDATA[`MIRQ_IRQ_W-1:0]) & VALID) == '0))
      else $error("Disable write left a source unmasked");
   AST_MASK_READ: assert property (RD && hit(ADDR, `MIRQ_OFS_IMASK) |=> // [R03]
      (RDATA == {18'h00000, $past(mask_q)}))
      else $error("Mask read returned wrong state");
   AST_ZERO_KEEP: assert property ((wr_en || wr_dis) && (WDATA[`MIRQ_IRQ_W-1:0] == '0) |=> // [R04]
      $stable(mask_q))
      else $error("Zero write changed the mask");
   AST_IRQ_RISE: assert property ((|(EVENT_IN & `MIRQ_IRQ_EXT & ~mask_q)) && !wr_dis |=> // [R05]
      IRQ)
      else $error("Unmasked event did not raise the interrupt");
   AST_MAN_BACK: assert property (wr_man && !mdio_busy |=> // [R06]
      (man_q == $past(WDATA)))
      else $error("Management word not stored as written");
   AST_RD_DATA: assert property (mdio_done && (man_q.op == `MIRQ_OP_READ) && !wr_man |=> // [R07]
      (man_q.data == $past(mdio_rd)))
      else $error("Read data not placed in data field");
   AST_BAD_FRAME: assert property (wr_man && !mdio_busy && !frame_ok(mirq_pkg::mirq_man_s'(WDATA)) |-> // [R09]
      !mdio_start ##2 stat_q[`MIRQ_IRQ_MGMT])
      else $error("Invalid frame was sent or not flagged");
   AST_DONE_IDLE: assert property (mdio_done && !mdio_start |=> // [R11]
      stat_q[`MIRQ_IRQ_MGMT] && !mdio_busy)
      else $error("Done did not flag or leave logic busy");
   AST_PAUSE_HOLD: assert property (!wr_pt && !PAUSE_LOAD && !tick |=> // [R12]
      $stable(pause_q))
      else $error("Pause count moved off its quantum");
   AST_PTZ: assert property (ptz_evt |=> // [R13]
      (pause_q == 16'h0000) && stat_q[`MIRQ_IRQ_PTZ])
      else $error("Pause zero not flagged");
   AST_HASH: assert property (wr_hh |=> // [R15]
      (HASH_FILTER[63:32] == $past(WDATA)) && $stable(HASH_FILTER[31:0]))
      else $error("Hash high write wrong");

   COV_MGMT_READ: cover property (mdio_start ##1 mdio_busy ##[1:1000] mdio_done);
   COV_PTZ: cover property (ptz_evt ##1 IRQ);
   COV_SET_ON_CLEAR: cover property (rd_st && (set_v != '0));
endmodule
`default_nettype wire

// File: tb/mirq_phy_model.sv
// Purpose: Behavioural PHY on the serial management link.
// Assumes: Host presents bits on MDC fall and samples on MDC rise.
// Notes:   The line idles high through a pull-up when nobody drives it.
`timescale 1ns/100ps
`default_nettype none
module mirq_phy_model #(
   parameter logic [15:0] RD_BASE = 16'hA5C3
) (
   input wire logic MDC,
   input wire logic MDIO_OUT,
   input wire logic MDIO_OE_N,
   output logic MDIO_IN
);
   logic [6:0] bit_cnt = 7'h00;
   logic [63:0] shift_q = 64'h0;
   logic [31:0] last_word = 32'h0;
   logic [1:0] op_q = 2'h0;
   logic [4:0] reg_q = 5'h00;
   logic [15:0] rd_word;
   logic rd_phase;
   int frames = 0;
   // Count bits from the first one driven; on a read, turnaround and data follow undriven
   always @(posedge MDC)
   begin
      if (!MDIO_OE_N || bit_cnt != 7'h00)
      begin
         shift_q = {shift_q[62:0], MDIO_IN};
         bit_cnt = bit_cnt + 7'h01;
         if (bit_cnt == 7'h2E)
         begin
            op_q = shift_q[11:10];
            reg_q = shift_q[4:0];
         end
         if (bit_cnt == 7'h40)
         begin
            last_word = shift_q[31:0];
            frames++;
            bit_cnt = 7'h00;
         end
      end
   end
   // Answer a read with a word tied to the register address, MSB first
   assign rd_word = RD_BASE ^ {11'h000, reg_q};
   assign rd_phase = (op_q == 2'h2) && (bit_cnt >= 7'h30);
   assign MDIO_IN = !MDIO_OE_N ? MDIO_OUT : rd_phase ? rd_word[4'hF - bit_cnt[3:0]] : 1'b1;
endmodule
`default_nettype wire

// File: tb/mirq_regs_tb.sv
// Purpose: Self-checking bench of the interrupt, management and filter bank.
// Assumes: Short pause quantum and management clock to keep the run brief.
// Notes:   Every wait is bounded; an idle wait that runs out ends the run.
`include "mirq_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module mirq_regs_tb;
   localparam int QCLK = 4;
   localparam int HALF = 2;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [13:0] ev = 14'h0;
   logic pload = 1'b0;
   logic [15:0] pval = 16'h0;
   logic [31:0] rdata;
   logic [63:0] hash;
   logic [31:0] sa;
   logic pact, irq, mdc, mdio_in, mdio_out, mdio_oe_n;
   logic [31:0] rv;
   logic [31:0] w;
   int n_mismatch = 0;
   int compares = 0;
   int k;
   int f;

   mirq_regs #(.QUANTUM_CLKS(QCLK), .MDC_HALF_CLKS(HALF)) u_mirq_regs (
      .CLK(clk), .NRST(nrst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
      .EVENT_IN(ev), .PAUSE_LOAD(pload), .PAUSE_VALUE(pval), .PAUSE_ACTIVE(pact), .IRQ(irq),
      .HASH_FILTER(hash), .SPEC_ADDR_LOW(sa), .MDC(mdc), .MDIO_IN(mdio_in), .MDIO_OUT(mdio_out),
      .MDIO_OE_N(mdio_oe_n));
   mirq_phy_model u_mirq_phy_model (.MDC(mdc), .MDIO_OUT(mdio_out), .MDIO_OE_N(mdio_oe_n), .MDIO_IN(mdio_in));

   // Free-running system clock
   initial
   begin
      forever #5 clk = ~clk;
   end

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic final_report();
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // Bus cycles: one-cycle strobes launched right after an edge
   task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask

   task automatic pulse(input logic [13:0] b);
      @(posedge clk);
      ev <= b;
      @(posedge clk);
      ev <= 14'h0;
      #1;
   endtask

   // Poll the idle bit; a frame is 64 bits of 2*HALF cycles each
   task automatic wait_idle();
      k = 0;
      rv = 32'h0;
      while (rv[`MIRQ_MSTAT_IDLE] !== 1'b1 && k < 400)
      begin
         bus_rd(`MIRQ_OFS_MSTAT, rv);
         k++;
      end
      if (k >= 400)
      begin
         n_mismatch++;
         final_report();
      end
   endtask

   task automatic t_reset();
      logic [7:0] offs [7] = '{`MIRQ_OFS_IEN, `MIRQ_OFS_IDIS, `MIRQ_OFS_MAN, `MIRQ_OFS_PAUSE,
                               `MIRQ_OFS_HASH_LO, `MIRQ_OFS_SA1_LO, 8'h3C};
      bus_rd(`MIRQ_OFS_IMASK, rv);
      check("mask", rv, {18'h0, `MIRQ_RST_MASK});
      for (int i = 0; i < 7; i++)
      begin
         bus_rd(offs[i], rv);
         check("reset", rv, 32'h0);
      end
      check("idle", {29'h0, mdc, mdio_oe_n, irq}, 32'h2);
   endtask

   task automatic t_irq();
      bus_wr(`MIRQ_OFS_IEN, 32'hFFFFFFFF);
      bus_rd(`MIRQ_OFS_IMASK, rv);
      check("mask", rv, 32'h0);
      bus_wr(`MIRQ_OFS_IDIS, 32'h40);
      bus_wr(`MIRQ_OFS_IEN, 32'h0);
      bus_wr(`MIRQ_OFS_IDIS, 32'h0);
      bus_rd(`MIRQ_OFS_IMASK, rv);
      check("mask", rv, 32'h40);
      pulse(14'h0040);
      check("irq", {31'h0, irq}, 32'h0);
      bus_wr(`MIRQ_OFS_IEN, 32'h40);
      #1;
      check("irq", {31'h0, irq}, 32'h1);
      bus_wr(`MIRQ_OFS_IDIS, 32'h40);
      // Clear the held source so each later read shows one bit only
      bus_rd(`MIRQ_OFS_STATUS, rv);
      check("status", rv, 32'h40);
      for (int b = 1; b < 13; b++)
      begin
         if (`MIRQ_IRQ_EXT & (1 << b))
         begin
            pulse(14'h1 << b);
            check("irq", {31'h0, irq}, {31'h0, b != 6});
            bus_rd(`MIRQ_OFS_STATUS, rv);
            check("status", rv, 32'h1 << b);
            check("irq", {31'h0, irq}, 32'h0);
         end
      end
      bus_wr(`MIRQ_OFS_IEN, 32'h40);
      pulse(14'h0300);
      bus_rd(`MIRQ_OFS_STATUS, rv);
      check("status", rv, 32'h0);
   endtask

   task automatic t_filter();
      bus_wr(`MIRQ_OFS_HASH_LO, 32'h12345678);
      bus_wr(`MIRQ_OFS_HASH_HI, 32'h9ABCDEF0);
      bus_wr(`MIRQ_OFS_SA1_LO, 32'hCAFEF00D);
      bus_rd(`MIRQ_OFS_HASH_HI, rv);
      check("hash_hi", rv, 32'h9ABCDEF0);
      check("hash_lo", hash[31:0], 32'h12345678);
      check("hash_hi", hash[63:32], 32'h9ABCDEF0);
      bus_rd(`MIRQ_OFS_SA1_LO, rv);
      check("sa1", rv, 32'hCAFEF00D);
      check("sa1", sa, 32'hCAFEF00D);
   endtask

   task automatic t_pause();
      bus_wr(`MIRQ_OFS_PAUSE, 32'hFFFF0003);
      // Step off the edge so the loaded count is visible
      #1;
      k = 0;
      while (pact === 1'b1 && k < 64)
      begin
         @(posedge clk);
         #1;
         k++;
      end
      check("pause_cycles", k, 3 * QCLK);
      bus_rd(`MIRQ_OFS_STATUS, rv);
      check("status", rv, 32'h2000);
      bus_rd(`MIRQ_OFS_STATUS, rv);
      check("status", rv, 32'h0);
      @(posedge clk);
      pval <= 16'h0002;
      pload <= 1'b1;
      @(posedge clk);
      pload <= 1'b0;
      bus_rd(`MIRQ_OFS_PAUSE, rv);
      check("pause", rv, 32'h2);
      repeat (2 * QCLK) @(posedge clk);
      bus_rd(`MIRQ_OFS_STATUS, rv);
      check("status", rv, 32'h2000);
   endtask

   task automatic t_mgmt();
      logic [31:0] bad [3] = '{32'h41A80000, 32'h71A80000, 32'h11A80000};
      w = {2'h1, 2'h1, 5'h03, 5'h0A, 2'h2, 16'hBEEF};
      bus_wr(`MIRQ_OFS_MAN, w);
      bus_rd(`MIRQ_OFS_MSTAT, rv);
      check("busy", {31'h0, rv[`MIRQ_MSTAT_IDLE]}, 32'h0);
      bus_wr(`MIRQ_OFS_MAN, 32'h0);
      wait_idle();
      bus_rd(`MIRQ_OFS_STATUS, rv);
      check("done", rv, 32'h1);
      bus_rd(`MIRQ_OFS_MAN, rv);
      check("man", rv, w);
      check("phy_word", u_mirq_phy_model.last_word, w);
      w = {2'h1, 2'h2, 5'h05, 5'h11, 2'h2, 16'h0000};
      bus_wr(`MIRQ_OFS_MAN, w);
      wait_idle();
      bus_rd(`MIRQ_OFS_MAN, rv);
      check("man_rd", rv, {w[31:16], 16'hA5C3 ^ 16'h0011});
      // Clear the done flag so each invalid frame must raise it afresh
      bus_rd(`MIRQ_OFS_STATUS, rv);
      check("done", rv, 32'h1);
      f = u_mirq_phy_model.frames;
      for (int i = 0; i < 3; i++)
      begin
         bus_wr(`MIRQ_OFS_MAN, bad[i]);
         wait_idle();
         bus_rd(`MIRQ_OFS_STATUS, rv);
         check("done", rv, 32'h1);
      end
      check("frames", u_mirq_phy_model.frames, f);
      check("mdc", {31'h0, mdc}, 32'h0);
   endtask

   // Reset for ten cycles, then each scenario in turn
   initial
   begin
      repeat (10) @(posedge clk);
      nrst <= 1'b1;
      t_reset();
      t_irq();
      t_filter();
      t_pause();
      t_mgmt();
      final_report();
   end
endmodule
`default_nettype wire
